// ---- cmp_ctrl_pkg.sv ----
// Package: register map, field positions and reset values of the comparator control block
package cmp_ctrl_pkg;
  localparam logic [7:0] comparator_one_control_addr = 8'hAC;
  localparam logic [7:0] comparator_two_control_addr = 8'hAD;
  localparam logic [7:0] port0_input_disable_addr    = 8'hF6;
  localparam logic [7:0] irq_enable_reg_zero_addr    = 8'hA8;
  localparam logic [7:0] irq_enable_reg_one_addr     = 8'hE8;
  localparam logic [7:0] irq_status_addr             = 8'hAE;
  localparam logic [7:0] irq_mask_addr               = 8'hAF;
  localparam logic [7:0] port0_pins_addr             = 8'h80;
  localparam logic [7:0] result_status_addr          = 8'hAB;
  // Control register field positions
  localparam int change_flag_bit      = 0;
  localparam int result_pin_enable_bit = 1;
  localparam int negative_select_bit  = 3;
  localparam int positive_select_bit  = 4;
  localparam int comparator_enable_bit = 5;
  localparam logic [7:0] control_used_mask = 8'h3B;
  // Enable bit positions
  localparam int global_irq_enable_bit = 7;
  localparam int comparator_one_irq_enable_bit = 5;
  localparam int comparator_two_irq_enable_bit = 2;
  localparam logic [7:0] control_reset     = 8'h00;
  localparam logic [7:0] input_disable_reset = 8'h00;
  localparam logic [7:0] enable_reset      = 8'h00;
  localparam logic [1:0] mask_reset        = 2'h0;
endpackage : cmp_ctrl_pkg

// ---- comparator_far_side.sv ----
// Far-side model: analog comparator stages and port-0 pin levels
`timescale 1ns/10ps
`default_nettype none
module comparator_far_side (
  input  wire logic            clk,
  input  wire logic [1:0][7:0] pos_level,
  input  wire logic [1:0][7:0] neg_level,
  input  wire logic [7:0]      pin_level,
  output logic      [1:0]      comparator_raw,
  output logic      [7:0]      port0_pins
);
  // Outputs move on the clock so that bench changes land off the sampling edge
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      comparator_raw[i] <= pos_level[i] > neg_level[i];
    end
    // Result pins are taken as push-pull, so levels switch within one clock
    port0_pins <= pin_level;
  end
endmodule : comparator_far_side
`default_nettype wire

// ---- dual_comparator_control.sv ----
// Dual comparator control: config registers, change flags, interrupt gating, port0 input disable
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dual_comparator_control
  import cmp_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic [1:0] comparator_raw,
  input  wire logic [7:0] port0_pins,
  output logic      [1:0] positive_input_select,
  output logic      [1:0] negative_input_select,
  output logic      [1:0] comparator_enable,
  output logic      [1:0] result_pin_enable,
  output logic      [1:0] result_pin,
  output logic      [7:0] port0_input_disable,
  output logic            comparator_irq,
  output logic            wake_request,
  output logic            irq
);
  import cmp_ctrl_pkg::*;

  typedef struct packed {
    logic [1:0][7:0] control;
    logic [7:0]      input_disable;
    logic [7:0]      irq_enable_reg_zero;
    logic [7:0]      irq_enable_reg_one;
    logic [1:0]      sync_a;
    logic [1:0]      sync_b;
    logic [1:0]      prev;
    logic [1:0]      status;
    logic [1:0]      mask;
    logic [7:0]      rdata;
  } state_type;

  state_type st;
  state_type next_st;
  logic [1:0] change;
  logic [1:0] irq_en_bits;
  logic [1:0] flags;

  // Edges only after two-stage sync, and only while the comparator is on
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      change[i] = st.control[i][comparator_enable_bit] && (st.sync_b[i] != st.prev[i]);
      flags[i]  = st.control[i][change_flag_bit];
    end
    irq_en_bits = {st.irq_enable_reg_one[comparator_two_irq_enable_bit],
                   st.irq_enable_reg_one[comparator_one_irq_enable_bit]};
  end

  always_comb begin
    next_st = st;
    next_st.sync_a = comparator_raw;
    next_st.sync_b = st.sync_a;
    next_st.prev   = st.sync_b;
    next_st.rdata  = 8'h00;
    for (int i = 0; i < 2; i++) begin
      if (wr && addr == (i == 0 ? comparator_one_control_addr : comparator_two_control_addr)) begin
        next_st.control[i] = wdata & control_used_mask;
        // A one written to the flag keeps it; software can only clear it
        next_st.control[i][change_flag_bit] = wdata[change_flag_bit] &
                                              st.control[i][change_flag_bit];
      end
      if (change[i]) begin
        next_st.control[i][change_flag_bit] = 1'b1;
        next_st.status[i] = 1'b1;
      end
    end
    if (wr) begin
      unique case (addr)
        port0_input_disable_addr: next_st.input_disable = wdata;
        irq_enable_reg_zero_addr: next_st.irq_enable_reg_zero = wdata;
        irq_enable_reg_one_addr:  next_st.irq_enable_reg_one = wdata;
        irq_mask_addr:            next_st.mask = wdata[1:0];
        default: ;
      endcase
    end
    if (rd) begin
      unique case (addr)
        comparator_one_control_addr: next_st.rdata = st.control[0];
        comparator_two_control_addr: next_st.rdata = st.control[1];
        port0_input_disable_addr:    next_st.rdata = st.input_disable;
        irq_enable_reg_zero_addr:    next_st.rdata = st.irq_enable_reg_zero;
        irq_enable_reg_one_addr:     next_st.rdata = st.irq_enable_reg_one;
        irq_mask_addr:               next_st.rdata = {6'h00, st.mask};
        result_status_addr:          next_st.rdata = {6'h00, st.sync_b};
        port0_pins_addr:             next_st.rdata = port0_pins & ~st.input_disable;
        irq_status_addr: begin
          next_st.rdata  = {6'h00, st.status};
          next_st.status = change; // Read clears, a new event in the same cycle survives
        end
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
      st.control[0]    <= control_reset;
      st.control[1]    <= control_reset;
      st.input_disable <= input_disable_reset;
      st.irq_enable_reg_zero          <= enable_reset;
      st.irq_enable_reg_one          <= enable_reset;
      st.mask          <= mask_reset;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    rdata = st.rdata;
    for (int i = 0; i < 2; i++) begin
      positive_input_select[i] = st.control[i][positive_select_bit];
      negative_input_select[i] = st.control[i][negative_select_bit];
      comparator_enable[i]     = st.control[i][comparator_enable_bit];
      result_pin_enable[i]     = st.control[i][result_pin_enable_bit];
      result_pin[i]            = st.sync_b[i] & st.control[i][result_pin_enable_bit];
    end
    port0_input_disable = st.input_disable;
    // No gated clock here: the request stays live while the CPU sleeps
    comparator_irq = st.irq_enable_reg_zero[global_irq_enable_bit] && |(flags & irq_en_bits);
    wake_request   = |(flags & irq_en_bits);
    irq            = |(st.status & st.mask);
  end

  a_irq_gating: assert property (@(posedge clk) disable iff (!resetn)
    comparator_irq == (st.irq_enable_reg_zero[7] && ((st.control[0][0] && st.irq_enable_reg_one[5]) ||
                       (st.control[1][0] && st.irq_enable_reg_one[2]))))
    else $error("comparator interrupt gating wrong");
  a_flag_sets: assert property (@(posedge clk) disable iff (!resetn)
    change[0] |=> st.control[0][0])
    else $error("change flag not set");
  a_set_wins: assert property (@(posedge clk) disable iff (!resetn)
    (change[1] && wr && addr == 8'hAD && !wdata[0]) |=> st.control[1][0])
    else $error("clear beat the set");
  a_flag_clears: assert property (@(posedge clk) disable iff (!resetn)
    (!change[0] && wr && addr == 8'hAC && !wdata[0]) |=> !st.control[0][0])
    else $error("flag not cleared");
  a_sync_once: assert property (@(posedge clk) disable iff (!resetn)
    change[0] |=> !change[0])
    else $error("one change seen twice");
  a_port_zero: assert property (@(posedge clk) disable iff (!resetn)
    (rd && addr == 8'h80) |=> ((rdata & $past(st.input_disable)) == 8'h00))
    else $error("disabled pin read nonzero");
  a_flag_held: assert property (@(posedge clk) disable iff (!resetn)
    (st.control[0][0] && !(wr && addr == 8'hAC)) |=> st.control[0][0])
    else $error("flag dropped by hardware");
  a_result_pin: assert property (@(posedge clk) disable iff (!resetn)
    !st.control[0][1] |-> !result_pin[0])
    else $error("result driven while pin disabled");
  a_disable_write: assert property (@(posedge clk) disable iff (!resetn)
    (wr && addr == 8'hF6) |=> port0_input_disable == $past(wdata))
    else $error("disable register not written");
  a_wake: assert property (@(posedge clk) disable iff (!resetn)
    (change[0] && st.irq_enable_reg_one[5]) |=> wake_request)
    else $error("no wake on enabled change");
endmodule : dual_comparator_control
`default_nettype wire

// ---- test_dual_comparator_control.sv ----
// Testbench: comparator control block through its register port and far-side model
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_dual_comparator_control;
  import cmp_ctrl_pkg::*;
  logic            clk = 0, resetn = 0, wr = 0, rd = 0;
  logic      [7:0] addr = 8'h00, wdata = 8'h00, pins = 8'hFF, rdata, p0_pins, p0_dis;
  logic [1:0][7:0] pos = '0, neg = '0;
  logic      [1:0] raw, psel, nsel, cen, rpen, rpin;
  logic            cirq, wake, irq;
  int              fails = 0, compares = 0, cycles = 0;
  comparator_far_side i_far (.clk(clk), .pos_level(pos), .neg_level(neg), .pin_level(pins),
    .comparator_raw(raw), .port0_pins(p0_pins));
  dual_comparator_control i_dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .comparator_raw(raw), .port0_pins(p0_pins),
    .positive_input_select(psel), .negative_input_select(nsel), .comparator_enable(cen),
    .result_pin_enable(rpen), .result_pin(rpin), .port0_input_disable(p0_dis),
    .comparator_irq(cirq), .wake_request(wake), .irq(irq));
  always #4 clk = ~clk;
  task report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // Ceiling well above the settle wait plus about a hundred bus cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      report_and_stop();
    end
  end
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : rd_reg
  task t_reset;
    rd_reg(comparator_one_control_addr, 8'h00);
    rd_reg(comparator_two_control_addr, 8'h00);
    rd_reg(port0_input_disable_addr, 8'h00);
    rd_reg(8'h33, 8'h00);
    `CHK({cirq, wake, irq}, 3'b000)
  endtask : t_reset
  task t_configs;
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 8; k++) begin
        // Unused bits written as zero
        wr_reg(8'hAC + c[7:0], {2'b00, 1'b1, k[2], k[1], 1'b0, k[0], 1'b0});
        #1 `CHK({psel[c], nsel[c], rpen[c], cen[c]}, {k[2:0], 1'b1})
        rd_reg(8'hAC + c[7:0], {2'b00, 1'b1, k[2], k[1], 1'b0, k[0], 1'b0});
      end
    end
  endtask : t_configs
  task t_change;
    wr_reg(comparator_one_control_addr, 8'h22);
    repeat (1250) @(posedge clk);
    wr_reg(comparator_one_control_addr, 8'h22);
    wr_reg(irq_mask_addr, 8'h01);
    pos[0] <= 8'h0A; neg[0] <= 8'h05;
    repeat (6) @(posedge clk);
    rd_reg(comparator_one_control_addr, 8'h23);
    rd_reg(result_status_addr, 8'h01);
    `CHK({rpin, cirq, wake, irq}, 5'b01001)
    rd_reg(irq_status_addr, 8'h01);
    rd_reg(irq_status_addr, 8'h00);
    wr_reg(irq_enable_reg_one_addr, 8'h20);
    #1 `CHK({cirq, wake}, 2'b01)
    wr_reg(irq_enable_reg_zero_addr, 8'h80);
    #1 `CHK(cirq, 1'b1)
    wr_reg(comparator_one_control_addr, 8'h22);
    #1 `CHK(cirq, 1'b0)
    pos[0] <= 8'h00;
    repeat (6) @(posedge clk);
    `CHK(cirq, 1'b1)
    wr_reg(comparator_one_control_addr, 8'h22);
    repeat (6) @(posedge clk);
    rd_reg(comparator_one_control_addr, 8'h22);
  endtask : t_change
  task t_port0;
    wr_reg(port0_input_disable_addr, 8'h30);
    #1 `CHK(p0_dis, 8'h30)
    rd_reg(port0_pins_addr, 8'hCF);
  endtask : t_port0
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_configs();
    t_change();
    t_port0();
    report_and_stop();
  end
endmodule : test_dual_comparator_control
`default_nettype wire
